// ==== logic/lcm_pkg.sv ====
// constants and carrier types for the lcd command and mode controller
package lcm_pkg;
	localparam int CLK_PERIOD_NS  = 4;
	localparam int OSC_PERIOD_NS  = 32000;
	localparam int OSC_DIV        = OSC_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SLOW_BLINK_MS  = 1000;
	localparam int FAST_BLINK_MS  = 500;
	localparam int SLOW_TICKS     = SLOW_BLINK_MS * 1000000 / OSC_PERIOD_NS;
	localparam int FAST_TICKS     = FAST_BLINK_MS * 1000000 / OSC_PERIOD_NS;
	localparam int PAGES          = 9;
	localparam int COLS           = 132;
	localparam int DEPTH          = PAGES * COLS;
	localparam logic [5:0] VOLUME_RST  = 6'h20;
	localparam logic [7:0] OP_VOL_MODE = 8'h81;
	localparam logic [7:0] OP_RMW      = 8'hE0;
	localparam logic [7:0] OP_END      = 8'hEE;
	localparam logic [7:0] OP_RESET    = 8'hE2;
	localparam logic [7:0] OP_NOP      = 8'hE3;
	localparam logic [6:0] OP_DISP     = 7'h57;
	localparam logic [6:0] OP_IND      = 7'h56;
	localparam logic [6:0] OP_ADC      = 7'h50;
	localparam logic [6:0] OP_REV      = 7'h53;
	localparam logic [6:0] OP_ALLON    = 7'h52;
	localparam logic [6:0] OP_BIAS     = 7'h51;
	localparam logic [4:0] OP_POWER    = 5'h05;
	localparam logic [4:0] OP_RATIO    = 5'h04;
	localparam logic [3:0] OP_PAGE     = 4'hB;
	localparam logic [3:0] OP_COL_HI   = 4'h1;
	localparam logic [3:0] OP_COL_LO   = 4'h0;
	localparam logic [3:0] OP_COM      = 4'hC;
	localparam logic [3:0] OP_TEST     = 4'hF;
	localparam logic [1:0] OP_START    = 2'h1;
	localparam logic [1:0] IND_OFF     = 2'h0;
	localparam logic [1:0] IND_SLOW    = 2'h1;
	localparam logic [1:0] IND_FAST    = 2'h2;

	typedef struct packed {
		logic       a0;
		logic [7:0] data;
	} lcm_byte_t;

	typedef struct packed {
		logic [5:0] volume;
		logic       bias_sel;
		logic       display_on;
		logic       all_on;
		logic       reverse;
		logic       adc;
		logic       com_rev;
		logic [2:0] power_ctrl;
		logic [2:0] ratio;
		logic [5:0] start_line;
		logic [1:0] indicator;
		logic       sleep;
		logic       standby;
		logic       osc_run;
		logic       supply_run;
		logic       drivers_high;
		logic       test_mode;
	} lcm_ctrl_t;
endpackage

// ==== logic/lcm_top.sv ====
// command decoder, mode control and display memory of the lcd controller
`timescale 1ns/1ns
module lcm_top #(
	parameter int OSC_DIV    = lcm_pkg::OSC_DIV,
	parameter int SLOW_TICKS = lcm_pkg::SLOW_TICKS,
	parameter int FAST_TICKS = lcm_pkg::FAST_TICKS
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// host parallel port pins
	input  wire logic             command_data_select,
	input  wire logic             rd_n,
	input  wire logic             wr_n,
	input  wire logic             hw_clear_n,
	input  wire logic [7:0]       data_in,
	output logic [7:0]            data_out,
	output logic                  data_oe_n,
	output logic                  host_ready,
	// mode and panel control
	output lcm_pkg::lcm_ctrl_t    ctrl,
	output logic                  blanking_output_n,
	output logic                  frame_polarity_output,
	output logic                  indicator_segment_output
);
	typedef struct packed {
		logic [2:0]         a0_s;
		logic [2:0]         rd_s;
		logic [2:0]         wr_s;
		logic [2:0]         clr_s;
		logic [7:0]         d1;
		logic [7:0]         d2;
		logic [7:0]         d3;
		logic               a0_a;
		logic               rd_a;
		logic               wr_a;
		logic               clr_a;
		lcm_pkg::lcm_byte_t slot0;
		lcm_pkg::lcm_byte_t slot1;
		logic [1:0]         cnt;
		logic               vol_mode;
		logic               ind_mode;
		logic               psave;
		logic [3:0]         page;
		logic [7:0]         col;
		logic               rmw;
		logic [7:0]         rmw_col;
		lcm_pkg::lcm_ctrl_t ctrl;
		logic [12:0]        osc_cnt;
		logic [14:0]        blink_cnt;
		logic               blink_ph;
		logic               fr;
		logic               ind_out;
		logic               dof_n;
		logic               ready;
		logic [7:0]         dout;
		logic               oe_n;
	} lcm_state_t;

	lcm_state_t q;
	lcm_state_t d;
	logic [7:0]  mem [0:lcm_pkg::DEPTH-1];
	logic [7:0]  rdata_q;
	logic [10:0] addr;
	logic        addr_ok;
	logic        mem_we;
	logic [7:0]  mem_wd;

	always_comb begin
		addr    = 11'(q.page * 11'(lcm_pkg::COLS)) + 11'(q.col);
		addr_ok = (q.page < 4'(lcm_pkg::PAGES)) && (q.col < 8'(lcm_pkg::COLS));
	end

	// memory survives every mode change, power save included
	always_ff @(posedge clk) begin
		if (ce) begin
			if (mem_we && addr_ok) begin
				mem[addr] <= mem_wd;
			end
			rdata_q <= addr_ok ? mem[addr] : 8'h00;
		end
	end

	function automatic lcm_pkg::lcm_ctrl_t ctrl_reset(input lcm_pkg::lcm_ctrl_t c);
		lcm_pkg::lcm_ctrl_t r;
		r            = c;
		r.volume     = lcm_pkg::VOLUME_RST;
		r.start_line = 6'h00;
		r.com_rev    = 1'b0;
		r.ratio      = 3'h0;
		r.indicator  = lcm_pkg::IND_OFF;
		r.test_mode  = 1'b0;
		return r;
	endfunction

	always_comb begin
		logic               wr_ev;
		logic               rd_end;
		logic               pop;
		logic               push;
		logic               reading;
		lcm_pkg::lcm_byte_t b;
		logic               was_save;
		d        = q;
		mem_we   = 1'b0;
		mem_wd   = 8'h00;
		pop      = 1'b0;
		push     = 1'b0;
		wr_ev    = 1'b0;
		rd_end   = 1'b0;
		reading  = 1'b0;
		b        = '0;
		was_save = 1'b0;
		// three-stage pin sync; change counted once stages two and three agree
		d.a0_s  = {q.a0_s[1:0], command_data_select};
		d.rd_s  = {q.rd_s[1:0], rd_n};
		d.wr_s  = {q.wr_s[1:0], wr_n};
		d.clr_s = {q.clr_s[1:0], hw_clear_n};
		d.d1    = data_in;
		d.d2    = q.d1;
		d.d3    = q.d2;
		if (q.a0_s[1] == q.a0_s[2]) begin
			d.a0_a = q.a0_s[2];
		end
		if (q.rd_s[1] == q.rd_s[2]) begin
			d.rd_a = q.rd_s[2];
		end
		if (q.wr_s[1] == q.wr_s[2]) begin
			d.wr_a = q.wr_s[2];
		end
		if (q.clr_s[1] == q.clr_s[2]) begin
			d.clr_a = q.clr_s[2];
		end
		wr_ev   = d.wr_a && !q.wr_a;
		rd_end  = d.rd_a && !q.rd_a;
		reading = !q.rd_a;
		// two-entry buffer; decoder stalls while a read holds the memory port
		push = wr_ev && (q.cnt != 2'd2);
		b    = q.slot0;
		if (q.cnt != 2'd0 && !reading) begin
			pop = 1'b1;
			d.slot0 = q.slot1;
			d.cnt   = q.cnt - 2'd1;
		end
		if (push) begin
			if (d.cnt == 2'd0) begin
				d.slot0 = '{a0: q.a0_a, data: q.d3};
			end else begin
				d.slot1 = '{a0: q.a0_a, data: q.d3};
			end
			d.cnt = d.cnt + 2'd1;
		end
		d.ready = (d.cnt != 2'd2);
		// read side: status or memory byte driven while strobe held low
		d.oe_n = !reading;
		if (reading && !q.a0_a) begin
			d.dout = {(q.cnt != 2'd0), q.ctrl.adc, !q.ctrl.display_on, !q.clr_a, 4'h0};
		end else if (reading) begin
			d.dout = rdata_q;
		end
		if (rd_end && q.a0_a && !q.rmw) begin
			d.col = q.col + 8'd1;
		end
		if (pop && b.a0) begin
			mem_we = 1'b1;
			mem_wd = b.data;
			d.col  = q.col + 8'd1;
		end else if (pop && q.vol_mode) begin
			d.ctrl.volume = b.data[5:0];
			d.vol_mode    = 1'b0;
		end else if (pop && q.ind_mode) begin
			d.ctrl.indicator = b.data[1:0];
			d.ind_mode       = 1'b0;
		end else if (pop) begin
			if (b.data == lcm_pkg::OP_VOL_MODE) begin
				d.vol_mode = 1'b1;
			end else if (b.data == lcm_pkg::OP_RMW) begin
				d.rmw     = 1'b1;
				d.rmw_col = q.col;
			end else if (b.data == lcm_pkg::OP_END) begin
				d.rmw = 1'b0;
				if (q.rmw) begin
					d.col = q.rmw_col;
				end
			end else if (b.data == lcm_pkg::OP_RESET) begin
				d.ctrl = ctrl_reset(q.ctrl);
				d.page = 4'h0;
				d.col  = 8'h00;
				d.rmw  = 1'b0;
				if (q.ctrl.standby) begin
					d.ctrl.standby = 1'b0;
					d.ctrl.sleep   = 1'b1;
					d.ctrl.osc_run = 1'b0;
				end
			end else if (b.data == lcm_pkg::OP_NOP) begin
				d.ctrl.test_mode = 1'b0;
			end else if (b.data[7:1] == lcm_pkg::OP_DISP) begin
				d.ctrl.display_on = b.data[0];
			end else if (b.data[7:1] == lcm_pkg::OP_IND) begin
				d.ind_mode = b.data[0];
				if (!b.data[0]) begin
					d.ctrl.indicator = lcm_pkg::IND_OFF;
				end
			end else if (b.data[7:1] == lcm_pkg::OP_ADC) begin
				d.ctrl.adc = b.data[0];
			end else if (b.data[7:1] == lcm_pkg::OP_REV) begin
				d.ctrl.reverse = b.data[0];
			end else if (b.data[7:1] == lcm_pkg::OP_ALLON) begin
				d.ctrl.all_on = b.data[0];
			end else if (b.data[7:1] == lcm_pkg::OP_BIAS) begin
				d.ctrl.bias_sel = b.data[0];
			end else if (b.data[7:3] == lcm_pkg::OP_POWER) begin
				d.ctrl.power_ctrl = b.data[2:0];
			end else if (b.data[7:3] == lcm_pkg::OP_RATIO) begin
				d.ctrl.ratio = b.data[2:0];
			end else if (b.data[7:4] == lcm_pkg::OP_PAGE) begin
				d.page = b.data[3:0];
			end else if (b.data[7:4] == lcm_pkg::OP_COL_HI) begin
				d.col = {b.data[3:0], q.col[3:0]};
			end else if (b.data[7:4] == lcm_pkg::OP_COL_LO) begin
				d.col = {q.col[7:4], b.data[3:0]};
			end else if (b.data[7:4] == lcm_pkg::OP_COM) begin
				d.ctrl.com_rev = b.data[3];
			end else if (b.data[7:4] == lcm_pkg::OP_TEST) begin
				d.ctrl.test_mode = 1'b1;
			end else if (b.data[7:6] == lcm_pkg::OP_START) begin
				d.ctrl.start_line = b.data[5:0];
			end
		end
		// power save is a compound state of display off plus all points on
		was_save = q.psave;
		d.psave  = !d.ctrl.display_on && d.ctrl.all_on;
		if (d.psave && !was_save) begin
			d.ctrl.sleep   = (d.ctrl.indicator == lcm_pkg::IND_OFF);
			d.ctrl.standby = (d.ctrl.indicator != lcm_pkg::IND_OFF);
		end else if (!d.psave) begin
			d.ctrl.sleep   = 1'b0;
			d.ctrl.standby = 1'b0;
		end
		d.ctrl.osc_run      = !d.ctrl.sleep;
		d.ctrl.supply_run   = !d.psave;
		d.ctrl.drivers_high = d.psave;
		d.dof_n             = !d.psave;
		// internal oscillator: a divided tick, halted in sleep
		if (q.ctrl.osc_run) begin
			if (q.osc_cnt == 13'(OSC_DIV - 1)) begin
				d.osc_cnt = 13'h0000;
				d.fr      = !q.fr;
				// at or above, so a switch to the faster rate never runs to the wrap
				if (q.blink_cnt >= 15'((q.ctrl.indicator == lcm_pkg::IND_FAST)
						? FAST_TICKS - 1 : SLOW_TICKS - 1)) begin
					d.blink_cnt = 15'h0000;
					d.blink_ph  = !q.blink_ph;
				end else begin
					d.blink_cnt = q.blink_cnt + 15'h0001;
				end
			end else begin
				d.osc_cnt = q.osc_cnt + 13'h0001;
			end
		end
		// lit segment is driven opposite the frame, unlit in phase with it
		unique case (q.ctrl.indicator)
			lcm_pkg::IND_OFF:  d.ind_out = d.fr;
			lcm_pkg::IND_SLOW: d.ind_out = d.fr ^ q.blink_ph;
			lcm_pkg::IND_FAST: d.ind_out = d.fr ^ q.blink_ph;
			default:           d.ind_out = !d.fr;
		endcase
		// clear pin held low resets volume, start line, com, ratio, indicator, test mode and address
		if (!q.clr_a) begin
			d.ctrl     = ctrl_reset(q.ctrl);
			d.page     = 4'h0;
			d.col      = 8'h00;
			d.rmw      = 1'b0;
			d.vol_mode = 1'b0;
			d.ind_mode = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q                 <= '0;
			q.a0_s            <= 3'h7;
			q.rd_s            <= 3'h7;
			q.wr_s            <= 3'h7;
			q.clr_s           <= 3'h7;
			q.a0_a            <= 1'b1;
			q.rd_a            <= 1'b1;
			q.wr_a            <= 1'b1;
			q.clr_a           <= 1'b1;
			q.ready           <= 1'b1;
			q.oe_n            <= 1'b1;
			q.dof_n           <= 1'b1;
			q.ctrl.volume     <= lcm_pkg::VOLUME_RST;
			q.ctrl.osc_run    <= 1'b1;
			q.ctrl.supply_run <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign data_out                 = q.dout;
	assign data_oe_n                = q.oe_n;
	assign host_ready               = q.ready;
	assign ctrl                     = q.ctrl;
	assign blanking_output_n        = q.dof_n;
	assign frame_polarity_output    = q.fr;
	assign indicator_segment_output = q.ind_out;
endmodule

// ==== test/lcm_monitor.sv ====
// assertion checker for the lcd command and mode controller
`timescale 1ns/1ns
module lcm_monitor (
	// clock and reset
	input wire logic               clk,
	input wire logic               rst,
	// watched pins
	input wire logic               command_data_select,
	input wire logic               hw_clear_n,
	input wire logic [7:0]         data_out,
	input wire logic               data_oe_n,
	input wire logic               blanking_output_n,
	input wire logic               frame_polarity_output,
	input wire logic               indicator_segment_output,
	input wire lcm_pkg::lcm_ctrl_t ctrl
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	property p_one_mode; !(ctrl.sleep && ctrl.standby); endproperty
	a_one_mode: assert property (p_one_mode) else $error("sleep and standby both set");
	property p_stby_ind; $rose(ctrl.standby) |-> ctrl.indicator != lcm_pkg::IND_OFF; endproperty
	a_stby_ind: assert property (p_stby_ind) else $error("standby with indicator off");
	property p_sleep_ind;
		$rose(ctrl.sleep) && !$past(ctrl.standby) |-> ctrl.indicator == lcm_pkg::IND_OFF;
	endproperty
	a_sleep_ind: assert property (p_sleep_ind) else $error("sleep with indicator on");
	property p_cause; $rose(ctrl.sleep || ctrl.standby) |-> !ctrl.display_on && ctrl.all_on; endproperty
	a_cause: assert property (p_cause) else $error("power save without its cause");
	property p_blank; $rose(ctrl.sleep || ctrl.standby) |-> ##[0:2] !blanking_output_n; endproperty
	a_blank: assert property (p_blank) else $error("blanking output not low");
	property p_sleep_stop;
		ctrl.sleep [*2] |-> !ctrl.osc_run && ctrl.drivers_high && !ctrl.supply_run;
	endproperty
	a_sleep_stop: assert property (p_sleep_stop) else $error("sleep left something running");
	property p_stby_run;
		ctrl.standby [*2] |-> ctrl.osc_run && ctrl.drivers_high && !ctrl.supply_run;
	endproperty
	a_stby_run: assert property (p_stby_run) else $error("standby state wrong");
	property p_status;
		!command_data_select [*8] ##0 !data_oe_n [*2] |-> data_out[3:0] == 4'h0;
	endproperty
	a_status: assert property (p_status) else $error("status low nibble not zero");
	property p_clear;
		!hw_clear_n [*6] |-> !ctrl.test_mode && ctrl.volume == lcm_pkg::VOLUME_RST;
	endproperty
	a_clear: assert property (p_clear) else $error("clear pin did not clear");
	property p_dark;
		(ctrl.indicator == lcm_pkg::IND_OFF) [*3] |-> indicator_segment_output == frame_polarity_output;
	endproperty
	a_dark: assert property (p_dark) else $error("dark indicator differs from frame");
endmodule
bind lcm_top lcm_monitor u_mon (.clk(clk), .rst(rst), .command_data_select(command_data_select),
	.hw_clear_n(hw_clear_n), .data_out(data_out), .data_oe_n(data_oe_n),
	.blanking_output_n(blanking_output_n), .frame_polarity_output(frame_polarity_output),
	.indicator_segment_output(indicator_segment_output), .ctrl(ctrl));

// ==== test/lcm_host.sv ====
// host processor model driving the parallel port
`timescale 1ns/1ns
module lcm_host (
	// clock
	input wire logic       clk,
	// device answers
	input wire logic       host_ready,
	input wire logic [7:0] data_out,
	input wire logic       data_oe_n,
	// pins driven by the host
	output logic           command_data_select,
	output logic           rd_n,
	output logic           wr_n,
	output logic [7:0]     data_in
);
	logic [7:0] hd = 8'h00;
	logic       den = 1'b0;
	// a released bus shows the inverse, never a stale copy
	assign data_in = den ? hd : (!data_oe_n ? data_out : ~hd);
	initial begin
		command_data_select = 1'b0;
		rd_n = 1'b1;
		wr_n = 1'b1;
	end
	// pairs go out back to back; nothing else is sent between them
	task automatic wr(input logic a0, input logic [7:0] d);
		int n;
		n = 0;
		while (host_ready !== 1'b1 && n < 200) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		command_data_select <= a0;
		hd <= d;
		den <= 1'b1;
		repeat (4) @(posedge clk);
		wr_n <= 1'b0;
		repeat (5) @(posedge clk);
		wr_n <= 1'b1;
		repeat (5) @(posedge clk);
		den <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic rd(input logic a0, output logic [7:0] d);
		@(posedge clk);
		command_data_select <= a0;
		repeat (4) @(posedge clk);
		rd_n <= 1'b0;
		repeat (7) @(posedge clk);
		d = data_out;
		rd_n <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	task automatic hold_rd(input logic v);
		@(posedge clk);
		command_data_select <= 1'b0;
		rd_n <= v;
	endtask
endmodule

// ==== test/lcd_command_mode_control_tb_top.sv ====
// self-checking bench for the lcd command and mode controller
`timescale 1ns/1ns
module lcd_command_mode_control_tb_top;
	typedef struct packed {
		logic [7:0] cmd;
		logic [5:0] vol;
		logic [1:0] ind;
		logic [3:0] flg;
	} lcm_row_t;
	logic               clk = 1'b0;
	logic               rst = 1'b1;
	logic               hw_clear_n = 1'b1;
	logic               ce = 1'b1;
	logic               cds, rd_n, wr_n, data_oe_n, host_ready, blank_n, frame, column_drivers;
	logic [7:0]         data_in, data_out, d;
	lcm_pkg::lcm_ctrl_t ctrl;
	int                 err_count = 0;
	int                 samples_checked = 0;
	// flg nibble: sleep, standby, test mode, bias
	lcm_row_t rows [20] = '{{8'h81, 6'h20, 2'h0, 4'h0}, {8'hA5, 6'h25, 2'h0, 4'h0},
		{8'hA3, 6'h25, 2'h0, 4'h1}, {8'hAD, 6'h25, 2'h0, 4'h1}, {8'hAE, 6'h25, 2'h2, 4'h1},
		{8'hA5, 6'h25, 2'h2, 4'h5}, {8'hE2, 6'h20, 2'h0, 4'h9}, {8'hA4, 6'h20, 2'h0, 4'h1},
		{8'hAD, 6'h20, 2'h0, 4'h1}, {8'h01, 6'h20, 2'h1, 4'h1}, {8'hAD, 6'h20, 2'h1, 4'h1},
		{8'h03, 6'h20, 2'h3, 4'h1}, {8'hAC, 6'h20, 2'h0, 4'h1}, {8'hA2, 6'h20, 2'h0, 4'h0},
		{8'hF5, 6'h20, 2'h0, 4'h2}, {8'hE3, 6'h20, 2'h0, 4'h0}, {8'h81, 6'h20, 2'h0, 4'h0},
		{8'h3F, 6'h3F, 2'h0, 4'h0}, {8'hA5, 6'h3F, 2'h0, 4'h8}, {8'hAF, 6'h3F, 2'h0, 4'h0}};
	lcm_pkg::lcm_byte_t mseq [11] = '{9'h0B0, 9'h010, 9'h000, 9'h15A, 9'h0B1, 9'h011, 9'h003,
		9'h1C3, 9'h0B1, 9'h011, 9'h003};
	always #2 clk = ~clk;
	lcm_top #(.OSC_DIV(4), .SLOW_TICKS(6), .FAST_TICKS(3)) dut (.clk(clk), .rst(rst), .ce(ce),
		.command_data_select(cds), .rd_n(rd_n), .wr_n(wr_n), .hw_clear_n(hw_clear_n),
		.data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .host_ready(host_ready),
		.ctrl(ctrl), .blanking_output_n(blank_n), .frame_polarity_output(frame),
		.indicator_segment_output(column_drivers));
	lcm_host host (.clk(clk), .host_ready(host_ready), .data_out(data_out), .data_oe_n(data_oe_n),
		.command_data_select(cds), .rd_n(rd_n), .wr_n(wr_n), .data_in(data_in));
	task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("counts err_count %0d samples_checked %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk_rst();
		chk("reset", {6'h20, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0},
			{ctrl.volume, ctrl.osc_run, ctrl.sleep, ctrl.test_mode, blank_n, data_oe_n, 1'b0});
	endtask
	// lit flips with the blink phase; counts phase flips over 48 cycles
	task automatic blink_count(input int exp_t);
		int   tog;
		logic px;
		repeat (28) @(posedge clk);
		tog = 0;
		px  = column_drivers ^ frame;
		repeat (48) begin
			@(posedge clk);
			if ((column_drivers ^ frame) != px) begin
				tog++;
			end
			px = column_drivers ^ frame;
		end
		chk("blink toggles", 12'(exp_t), 12'(tog));
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk);
		chk_rst();
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		foreach (rows[i]) begin
			host.wr(1'b0, rows[i].cmd);
			chk("ctrl", {rows[i].vol, rows[i].ind, rows[i].flg}, {ctrl.volume, ctrl.indicator,
				ctrl.sleep, ctrl.standby, ctrl.test_mode, ctrl.bias_sel});
			chk("blank", {11'h000, ~|rows[i].flg[3:2]}, {11'h000, blank_n});
		end
		foreach (mseq[i]) host.wr(mseq[i].a0, mseq[i].data);
		host.rd(1'b1, d);
		chk("page col data", {4'h0, 8'hC3}, {4'h0, d});
		host.wr(1'b0, 8'hB0);
		host.wr(1'b0, 8'h10);
		host.wr(1'b0, 8'h00);
		// read/modify/write: read keeps the column, end restores it
		host.wr(1'b0, 8'hE0);
		host.rd(1'b1, d);
		chk("col zero data", {4'h0, 8'h5A}, {4'h0, d});
		host.wr(1'b1, 8'hA5);
		host.wr(1'b0, 8'hEE);
		host.rd(1'b1, d);
		chk("rmw end data", {4'h0, 8'hA5}, {4'h0, d});
		host.wr(1'b0, 8'hA1);
		host.rd(1'b0, d);
		chk("status", {4'h0, 8'h40}, {4'h0, d});
		// a held read stalls the decoder, so the buffer fills
		host.hold_rd(1'b0);
		host.wr(1'b0, 8'hA3);
		host.wr(1'b0, 8'hA2);
		chk("ready full", {11'h000, 1'b0}, {11'h000, host_ready});
		host.hold_rd(1'b1);
		repeat (12) @(posedge clk);
		chk("drained", {10'h000, 2'h1}, {10'h000, ctrl.bias_sel, host_ready});
		// enable low freezes the pin sync too, so the strobe is never seen
		ce <= 1'b0;
		host.wr(1'b0, 8'hA3);
		chk("frozen", {11'h000, 1'b0}, {11'h000, ctrl.bias_sel});
		ce <= 1'b1;
		// deliberate misuse, the only way to reach test mode
		host.wr(1'b0, 8'hF0);
		chk("test on", {11'h000, 1'b1}, {11'h000, ctrl.test_mode});
		hw_clear_n <= 1'b0;
		repeat (8) @(posedge clk);
		hw_clear_n <= 1'b1;
		repeat (6) @(posedge clk);
		chk("clear pin", {5'h00, 1'b0, 6'h20}, {5'h00, ctrl.test_mode, ctrl.volume});
		host.wr(1'b0, 8'hAD);
		host.wr(1'b0, 8'h03);
		chk("steady", {11'h000, 1'b1}, {11'h000, column_drivers ^ frame});
		host.wr(1'b0, 8'hAD);
		host.wr(1'b0, 8'h02);
		blink_count(4);
		host.wr(1'b0, 8'hAD);
		host.wr(1'b0, 8'h01);
		blink_count(2);
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		chk_rst();
		rst <= 1'b0;
		repeat (6) @(posedge clk);
		complete_run();
	end
endmodule
